// [rtl/iccp_pkg.sv]
/*
 Shared constants for the isolator channel command parser: command codes,
 response kinds, argument limits, calibration result codes and timing.
 Assumes a host front end that has already parsed program message text
 into decoded command words.
*/
package iccp_pkg;
   // Decoded command codes presented on the command port.
   localparam logic [3:0] CMD_CAL_QUERY = 4'h1;
   localparam logic [3:0] CMD_SETTINGS_QUERY = 4'h2;
   localparam logic [3:0] CMD_CALSTATE_QUERY = 4'h3;
   localparam logic [3:0] CMD_COUPLING_SET = 4'h4;
   localparam logic [3:0] CMD_COUPLING_QUERY = 4'h5;
   localparam logic [3:0] CMD_GAIN_SET = 4'h6;
   localparam logic [3:0] CMD_GAIN_QUERY = 4'h7;
   localparam logic [3:0] CMD_OFFSET_SET = 4'h8;
   localparam logic [3:0] CMD_OFFSET_QUERY = 4'h9;
   localparam logic [3:0] CMD_RANGE_SET = 4'ha;
   localparam logic [3:0] CMD_RANGE_QUERY = 4'hb;
   // Response kind tags that say which header the answer carries.
   localparam logic [2:0] RSP_CAL = 3'h1;
   localparam logic [2:0] RSP_SETTINGS = 3'h2;
   localparam logic [2:0] RSP_CALSTATE = 3'h3;
   localparam logic [2:0] RSP_COUPLING = 3'h4;
   localparam logic [2:0] RSP_GAIN = 3'h5;
   localparam logic [2:0] RSP_OFFSET = 3'h6;
   localparam logic [2:0] RSP_RANGE = 3'h7;
   // Coupling encodings: AC is numeric zero, DC numeric one.
   localparam logic COUPLING_AC = 1'b0;
   localparam logic COUPLING_DC = 1'b1;
   // Gain and offset argument limits, inclusive.
   localparam logic [7:0] ARG_MIN = 8'h37;
   localparam logic [7:0] ARG_MAX = 8'hff;
   // Range held in millivolts per division: 100 mV up to 200 V.
   localparam logic [17:0] RANGE_MIN_MV = 18'h00064;
   localparam logic [17:0] RANGE_MAX_MV = 18'h30d40;
   // Calibration result codes built as channel*100 (+10 for gain).
   localparam logic [8:0] CAL_OK = 9'h000;
   localparam logic [8:0] CAL_STEP_CH = 9'h064;
   localparam logic [8:0] CAL_GAIN_ADD = 9'h00a;
   // Reset values of the per-channel settings.
   localparam logic [7:0] GAIN_RESET = 8'h80;
   localparam logic [7:0] OFFSET_RESET = 8'h80;
   localparam logic [17:0] RANGE_RESET_MV = 18'h003e8;
   // Self-calibration step time per channel, and its cycle count.
   localparam int CAL_STEP_NS = 1000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CAL_STEP_CYC = (CAL_STEP_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
endpackage

// [rtl/iccp_parser.sv]
/*
 Channel control and self-calibration command interpreter. Takes decoded
 commands one at a time on a valid/ready port and answers queries on a
 one-cycle response strobe. Assumes one clock, an upstream text parser,
 and per-channel pass/fail flags from the analog calibration hardware,
 which arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module iccp_parser #(
   parameter int NUM_CH = 4
) (
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Command port.
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_code,
   input wire logic [2:0] cmd_chan,
   input wire logic [17:0] cmd_arg,
   output logic cmd_ready,
   // Calibration hardware flags, asynchronous, one bit per channel.
   input wire logic [3:0] cal_offset_fail,
   input wire logic [3:0] cal_gain_fail,
   // Response port.
   output logic rsp_valid,
   output logic [2:0] rsp_kind,
   output logic [2:0] rsp_chan,
   output logic [8:0] rsp_code,
   output logic rsp_coupling,
   output logic [7:0] rsp_gain,
   output logic [7:0] rsp_offset,
   output logic [17:0] rsp_range_mv,
   // Error strobe and calibration activity.
   output logic exec_error,
   output logic cal_busy
);
   // The flag ports are four bits wide; more channels cannot be served.
   // This is refused while the design is elaborated, not while it runs.
   if (NUM_CH < 1 || NUM_CH > 4) begin : gen_bad_num_ch
      $error("NUM_CH must be 1 to 4");
   end

   // Sequencer states.
   typedef enum logic [1:0] {
      ICCP_IDLE = 2'b01,
      ICCP_CAL = 2'b10
   } iccp_state_t;

   // Settings stores, one entry per channel.
   logic coupling_q [NUM_CH];
   logic [7:0] gain_q [NUM_CH];
   logic [7:0] offset_q [NUM_CH];
   logic [17:0] range_q [NUM_CH];
   logic [NUM_CH-1:0] calibrated_q;
   iccp_state_t state_q;
   // Step counter and channel under calibration.
   logic [7:0] step_cnt_q;
   logic [2:0] cal_ch_q;
   logic [8:0] cal_result_q;
   // Two-stage synchronisers for the failure flags.
   logic [3:0] ofs_meta_q, ofs_sync_q, gn_meta_q, gn_sync_q;

   // Checks that a channel index lies within 1..NUM_CH.
   function automatic logic chan_ok(input logic [2:0] ch);
      chan_ok = (ch != 3'h0) && (32'(ch) <= NUM_CH);
   endfunction

   // Zero-based slot of a channel index, only valid after chan_ok.
   function automatic logic [1:0] slot(input logic [2:0] ch);
      slot = 2'(ch - 3'h1);
   endfunction

   logic take;
   logic idx_ok;
   logic arg8_ok;
   logic rng_ok;
   logic [1:0] sl;
   assign take = clk_en && cmd_valid && state_q == ICCP_IDLE;
   assign idx_ok = chan_ok(cmd_chan);
   assign arg8_ok = cmd_arg >= 18'(iccp_pkg::ARG_MIN)
      && cmd_arg <= 18'(iccp_pkg::ARG_MAX);
   assign rng_ok = cmd_arg >= iccp_pkg::RANGE_MIN_MV
      && cmd_arg <= iccp_pkg::RANGE_MAX_MV;
   assign sl = slot(cmd_chan);

   // Flag synchronisers; the first stage feeds only the second.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ofs_meta_q <= 4'h0;
         ofs_sync_q <= 4'h0;
         gn_meta_q <= 4'h0;
         gn_sync_q <= 4'h0;
      end else if (clk_en) begin
         ofs_meta_q <= cal_offset_fail;
         ofs_sync_q <= ofs_meta_q;
         gn_meta_q <= cal_gain_fail;
         gn_sync_q <= gn_meta_q;
      end
   end

   // Ready only while idle; one command at a time keeps arrival order.
   // Only a command actually taken drops ready. A command that is
   // offered while ready is low must not hold ready low, or a host that
   // waits with valid raised during calibration would never be served.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cmd_ready <= 1'b0;
      end else if (clk_en) begin
         cmd_ready <= !(take && cmd_ready) && state_q == ICCP_IDLE;
      end
   end

   // Settings writes; rejected commands leave stores unchanged.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            coupling_q[i] <= iccp_pkg::COUPLING_DC;
            gain_q[i] <= iccp_pkg::GAIN_RESET;
            offset_q[i] <= iccp_pkg::OFFSET_RESET;
            range_q[i] <= iccp_pkg::RANGE_RESET_MV;
         end
      end else if (take && cmd_ready && idx_ok) begin
         case (cmd_code)
            iccp_pkg::CMD_COUPLING_SET: begin
               // Only numeric 0 (AC) and 1 (DC) are meaningful.
               if (cmd_arg <= 18'h00001) begin
                  coupling_q[sl] <= cmd_arg[0];
               end
            end
            iccp_pkg::CMD_GAIN_SET: begin
               if (arg8_ok) begin
                  gain_q[sl] <= cmd_arg[7:0];
               end
            end
            iccp_pkg::CMD_OFFSET_SET: begin
               if (arg8_ok) begin
                  offset_q[sl] <= cmd_arg[7:0];
               end
            end
            iccp_pkg::CMD_RANGE_SET: begin
               if (rng_ok) begin
                  range_q[sl] <= cmd_arg;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Error strobe for bad channel or out-of-span arguments.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         exec_error <= 1'b0;
      end else if (clk_en) begin
         exec_error <= 1'b0;
         if (take && cmd_ready && cmd_code != iccp_pkg::CMD_CAL_QUERY) begin
            case (cmd_code)
               iccp_pkg::CMD_COUPLING_SET:
                  exec_error <= !idx_ok || cmd_arg > 18'h00001;
               iccp_pkg::CMD_GAIN_SET, iccp_pkg::CMD_OFFSET_SET:
                  exec_error <= !idx_ok || !arg8_ok;
               iccp_pkg::CMD_RANGE_SET:
                  exec_error <= !idx_ok || !rng_ok;
               default:
                  exec_error <= !idx_ok;
            endcase
         end
      end
   end

   // Self-calibration sequencer: one timed step per channel, first
   // failure found is kept, since the answer is a single integer.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ICCP_IDLE;
         step_cnt_q <= 8'h00;
         cal_ch_q <= 3'h0;
         cal_result_q <= iccp_pkg::CAL_OK;
         calibrated_q <= '0;
      end else if (clk_en) begin
         case (state_q)
            ICCP_IDLE: begin
               if (take && cmd_ready
                   && cmd_code == iccp_pkg::CMD_CAL_QUERY) begin
                  state_q <= ICCP_CAL;
                  step_cnt_q <= 8'(iccp_pkg::CAL_STEP_CYC - 1);
                  cal_ch_q <= 3'h1;
                  cal_result_q <= iccp_pkg::CAL_OK;
                  calibrated_q <= '0;
               end
            end
            ICCP_CAL: begin
               if (step_cnt_q != 8'h00) begin
                  step_cnt_q <= step_cnt_q - 8'h01;
               end else begin
                  if (cal_result_q == iccp_pkg::CAL_OK) begin
                     if (ofs_sync_q[slot(cal_ch_q)]) begin
                        cal_result_q <= 9'(cal_ch_q
                           * iccp_pkg::CAL_STEP_CH);
                     end else if (gn_sync_q[slot(cal_ch_q)]) begin
                        cal_result_q <= 9'(cal_ch_q * iccp_pkg::CAL_STEP_CH
                           + iccp_pkg::CAL_GAIN_ADD);
                     end
                  end
                  if (!ofs_sync_q[slot(cal_ch_q)]
                      && !gn_sync_q[slot(cal_ch_q)]) begin
                     calibrated_q[slot(cal_ch_q)] <= 1'b1;
                  end
                  if (32'(cal_ch_q) == NUM_CH) begin
                     state_q <= ICCP_IDLE;
                  end else begin
                     cal_ch_q <= cal_ch_q + 3'h1;
                     step_cnt_q <= 8'(iccp_pkg::CAL_STEP_CYC - 1);
                  end
               end
            end
            default: begin
               state_q <= ICCP_IDLE;
            end
         endcase
      end
   end

   // Busy flag mirrors the calibration state for outside logic.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cal_busy <= 1'b0;
      end else if (clk_en) begin
         cal_busy <= (state_q == ICCP_CAL);
      end
   end

   logic cal_done;
   assign cal_done = state_q == ICCP_CAL && step_cnt_q == 8'h00
      && 32'(cal_ch_q) == NUM_CH;

   // Response formation; the final calibration step answers *CAL? with
   // the already-decided code or this last channel's outcome.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid <= 1'b0;
         rsp_kind <= 3'h0;
         rsp_chan <= 3'h0;
         rsp_code <= iccp_pkg::CAL_OK;
         rsp_coupling <= iccp_pkg::COUPLING_DC;
         rsp_gain <= 8'h00;
         rsp_offset <= 8'h00;
         rsp_range_mv <= 18'h00000;
      end else if (clk_en) begin
         rsp_valid <= 1'b0;
         if (cal_done) begin
            rsp_valid <= 1'b1;
            rsp_kind <= iccp_pkg::RSP_CAL;
            rsp_chan <= 3'h0;
            if (cal_result_q != iccp_pkg::CAL_OK) begin
               rsp_code <= cal_result_q;
            end else if (ofs_sync_q[slot(cal_ch_q)]) begin
               rsp_code <= 9'(cal_ch_q * iccp_pkg::CAL_STEP_CH);
            end else if (gn_sync_q[slot(cal_ch_q)]) begin
               rsp_code <= 9'(cal_ch_q * iccp_pkg::CAL_STEP_CH
                  + iccp_pkg::CAL_GAIN_ADD);
            end else begin
               rsp_code <= iccp_pkg::CAL_OK;
            end
         end else if (take && cmd_ready && idx_ok) begin
            rsp_chan <= cmd_chan;
            rsp_coupling <= coupling_q[sl];
            rsp_gain <= gain_q[sl];
            rsp_offset <= offset_q[sl];
            rsp_range_mv <= range_q[sl];
            rsp_code <= {8'h00, calibrated_q[sl]};
            case (cmd_code)
               iccp_pkg::CMD_SETTINGS_QUERY: begin
                  rsp_valid <= 1'b1;
                  rsp_kind <= iccp_pkg::RSP_SETTINGS;
               end
               iccp_pkg::CMD_CALSTATE_QUERY: begin
                  rsp_valid <= 1'b1;
                  rsp_kind <= iccp_pkg::RSP_CALSTATE;
               end
               iccp_pkg::CMD_COUPLING_QUERY: begin
                  rsp_valid <= 1'b1;
                  rsp_kind <= iccp_pkg::RSP_COUPLING;
               end
               iccp_pkg::CMD_GAIN_QUERY: begin
                  rsp_valid <= 1'b1;
                  rsp_kind <= iccp_pkg::RSP_GAIN;
               end
               iccp_pkg::CMD_OFFSET_QUERY: begin
                  rsp_valid <= 1'b1;
                  rsp_kind <= iccp_pkg::RSP_OFFSET;
               end
               iccp_pkg::CMD_RANGE_QUERY: begin
                  rsp_valid <= 1'b1;
                  rsp_kind <= iccp_pkg::RSP_RANGE;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // A calibration answer is only ever one of the nine legal codes.
   chk_cal_code_legal: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rsp_valid && rsp_kind == iccp_pkg::RSP_CAL |->
      rsp_code inside {9'd0, 9'd100, 9'd110, 9'd200, 9'd210,
                       9'd300, 9'd310, 9'd400, 9'd410})
      else $error("illegal calibration code");

   // The calibration answer comes within the sequence time.
   chk_cal_answers: assert property (@(posedge core_clk)
      disable iff (!resetn)
      clk_en && take && cmd_ready && cmd_code == iccp_pkg::CMD_CAL_QUERY
      |-> ##[1:100] (rsp_valid && rsp_kind == iccp_pkg::RSP_CAL))
      else $error("calibration query unanswered");

   // A clean calibration with no flags answers zero.
   chk_cal_zero: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rsp_valid && rsp_kind == iccp_pkg::RSP_CAL
      && $past(ofs_sync_q, 1) == 4'h0 && $past(gn_sync_q, 1) == 4'h0
      && cal_result_q == iccp_pkg::CAL_OK |-> rsp_code == 9'd0)
      else $error("clean calibration not zero");

   // A good gain write on channel one reads back next cycle.
   chk_gain_store: assert property (@(posedge core_clk)
      disable iff (!resetn)
      take && cmd_ready && cmd_code == iccp_pkg::CMD_GAIN_SET
      && cmd_chan == 3'h1 && arg8_ok |=> gain_q[0] == $past(cmd_arg[7:0]))
      else $error("gain not stored");

   // An offset write with bad argument raises the error strobe next cycle.
   chk_offset_reject: assert property (@(posedge core_clk)
      disable iff (!resetn)
      clk_en && take && cmd_ready && cmd_code == iccp_pkg::CMD_OFFSET_SET
      && !arg8_ok |=> exec_error)
      else $error("bad offset not flagged");

   // Range query answers lie within the legal range span.
   chk_range_read: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rsp_valid && rsp_kind == iccp_pkg::RSP_RANGE |->
      rsp_range_mv >= iccp_pkg::RANGE_MIN_MV
      && rsp_range_mv <= iccp_pkg::RANGE_MAX_MV)
      else $error("range out of span");

   // Calibrated-state answer is one bit wide.
   chk_calstate_bit: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rsp_valid && rsp_kind == iccp_pkg::RSP_CALSTATE |->
      rsp_code[8:1] == 8'h00)
      else $error("calibrated state not 0 or 1");

   // No command is taken while calibration runs.
   chk_order_hold: assert property (@(posedge core_clk)
      disable iff (!resetn)
      state_q == ICCP_CAL |-> !cmd_ready)
      else $error("ready during calibration");
endmodule
`default_nettype wire

// [bench/iccp_host_model.sv]
/*
 Host model for the channel command parser: offers one decoded command at a
 time and holds it until the parser takes it. Assumes the bench calls send
 from one process only and watches stuck after each call.
*/
`timescale 1ns/1ns
`default_nettype none
module iccp_host_model (
   // Clock and enable, watched to know when a command is taken.
   input wire logic core_clk,
   input wire logic clk_en,
   // Command port toward the parser.
   output var logic cmd_valid,
   output var logic [3:0] cmd_code,
   output var logic [2:0] cmd_chan,
   output var logic [17:0] cmd_arg,
   input wire logic cmd_ready,
   // Raised when a command was never taken within the bound.
   output var logic stuck
);
   // Idle values until the first command.
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 4'h0;
      cmd_chan = 3'h0;
      cmd_arg = 18'h0;
      stuck = 1'b0;
   end

   // One command, held until a rising edge sees ready and enable high.
   // Ready is a register, so its value at the falling edge is the value
   // sampled at the next rising edge; this avoids a race on the edge.
   // Commands go out strictly one after another.
   task automatic send(input logic [3:0] code, input logic [2:0] chan,
      input logic [17:0] arg);
      int n;
      n = 0;
      @(posedge core_clk);
      #2;
      cmd_valid = 1'b1;
      cmd_code = code;
      cmd_chan = chan;
      cmd_arg = arg;
      @(negedge core_clk);
      while (!(cmd_ready === 1'b1 && clk_en === 1'b1) && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 500) begin
         stuck = 1'b1;
      end
      @(posedge core_clk);
      #2;
      // Released lines show the inverse so no stale value looks valid.
      cmd_valid = 1'b0;
      cmd_code = ~code;
      cmd_chan = ~chan;
      cmd_arg = ~arg;
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
/*
 Self-checking bench for the channel command parser. Assumes the parser
 package, a 20 MHz clock and the host model for the command port.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   // Clock, reset, enable and calibration flags driven by the bench.
   logic core_clk, resetn, clk_en;
   logic [3:0] cal_offset_fail, cal_gain_fail;
   // Command and response wires.
   logic cmd_valid, cmd_ready, rsp_valid, rsp_coupling, exec_error, cal_busy;
   logic [3:0] cmd_code;
   logic [2:0] cmd_chan, rsp_kind, rsp_chan;
   logic [17:0] cmd_arg, rsp_range_mv;
   logic [8:0] rsp_code;
   logic [7:0] rsp_gain, rsp_offset;
   logic stuck;
   int failures = 0;
   int check_count = 0;

   iccp_parser #(.NUM_CH(4)) i_dut (.core_clk(core_clk), .resetn(resetn),
      .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_chan(cmd_chan), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
      .cal_offset_fail(cal_offset_fail), .cal_gain_fail(cal_gain_fail),
      .rsp_valid(rsp_valid), .rsp_kind(rsp_kind), .rsp_chan(rsp_chan),
      .rsp_code(rsp_code), .rsp_coupling(rsp_coupling),
      .rsp_gain(rsp_gain), .rsp_offset(rsp_offset),
      .rsp_range_mv(rsp_range_mv), .exec_error(exec_error),
      .cal_busy(cal_busy));

   iccp_host_model i_host (.core_clk(core_clk), .clk_en(clk_en),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_chan(cmd_chan),
      .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .stuck(stuck));

   // 50 ns clock.
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compares a value of any field, widened to 18 bits.
   task automatic cmp_val(input string name, input logic [17:0] exp,
      input logic [17:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   // Compares a single flag.
   task automatic cmp_bit(input string name, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %b seen %b", name, exp, got);
      end
   endtask

   // Sends one command; a command never taken ends the run.
   task automatic cmd(input logic [3:0] c, input logic [2:0] ch,
      input logic [17:0] a);
      i_host.send(c, ch, a);
      if (stuck !== 1'b0) begin
         failures++;
         $display("wrong value cmd_ready expected 1 seen 0");
         results();
      end
   endtask

   // Waits on falling edges for a response or an error pulse.
   task automatic wait_rsp(input int max, output logic got, output logic err);
      int n;
      got = 1'b0;
      err = 1'b0;
      for (n = 0; n < max && !got && !err; n++) begin
         @(negedge core_clk);
         got = (rsp_valid === 1'b1);
         err = (exec_error === 1'b1);
      end
   endtask

   // A query whose answer must come with its kind and channel.
   task automatic query(input logic [3:0] c, input logic [2:0] ch,
      input logic [2:0] kind, input int max);
      logic got, err;
      cmd(c, ch, 18'h0);
      wait_rsp(max, got, err);
      if (got !== 1'b1) begin
         failures++;
         $display("wrong value rsp_valid expected 1 seen %b", got);
         results();
      end
      cmp_val("rsp_kind", 18'(kind), 18'(rsp_kind));
      if (c !== iccp_pkg::CMD_CAL_QUERY) begin
         cmp_val("rsp_chan", 18'(ch), 18'(rsp_chan));
      end
   endtask

   // A setting command; bad says whether it must be refused.
   task automatic setc(input logic [3:0] c, input logic [2:0] ch,
      input logic [17:0] a, input logic bad);
      logic got, err;
      cmd(c, ch, a);
      wait_rsp(3, got, err);
      cmp_bit("exec_error", bad, err);
      cmp_bit("rsp_valid", 1'b0, got);
   endtask

   // Reads all settings of a channel, singly and together.
   task automatic check_chan(input logic [2:0] ch, input logic cpl,
      input logic [7:0] g, input logic [7:0] o, input logic [17:0] r);
      query(iccp_pkg::CMD_COUPLING_QUERY, ch, iccp_pkg::RSP_COUPLING, 4);
      cmp_bit("rsp_coupling", cpl, rsp_coupling);
      query(iccp_pkg::CMD_GAIN_QUERY, ch, iccp_pkg::RSP_GAIN, 4);
      cmp_val("rsp_gain", 18'(g), 18'(rsp_gain));
      query(iccp_pkg::CMD_OFFSET_QUERY, ch, iccp_pkg::RSP_OFFSET, 4);
      cmp_val("rsp_offset", 18'(o), 18'(rsp_offset));
      query(iccp_pkg::CMD_RANGE_QUERY, ch, iccp_pkg::RSP_RANGE, 4);
      cmp_val("rsp_range_mv", r, rsp_range_mv);
      query(iccp_pkg::CMD_SETTINGS_QUERY, ch, iccp_pkg::RSP_SETTINGS, 4);
      cmp_bit("set_coupling", cpl, rsp_coupling);
      cmp_val("set_gain", 18'(g), 18'(rsp_gain));
      cmp_val("set_offset", 18'(o), 18'(rsp_offset));
      cmp_val("set_range", r, rsp_range_mv);
   endtask

   // Runs self-calibration once, checks the busy flag, then waits for
   // the single answer of that same run and checks its code.
   task automatic cal_run(input int exp);
      logic got, err;
      cmd(iccp_pkg::CMD_CAL_QUERY, 3'h1, 18'h0);
      @(negedge core_clk);
      @(negedge core_clk);
      cmp_bit("cal_busy", 1'b1, cal_busy);
      wait_rsp(200, got, err);
      cmp_bit("cal_rsp_valid", 1'b1, got);
      cmp_val("rsp_kind", 18'(iccp_pkg::RSP_CAL), 18'(rsp_kind));
      cmp_val("rsp_code", 18'(exp), 18'(rsp_code));
   endtask

   // Stored values after reset, nothing calibrated.
   task automatic t_reset();
      check_chan(3'h2, 1'b1, 8'h80, 8'h80, 18'h003e8);
      query(iccp_pkg::CMD_CALSTATE_QUERY, 3'h1, iccp_pkg::RSP_CALSTATE, 4);
      cmp_val("calstate", 18'h0, 18'(rsp_code));
      $display("test reset done");
   endtask

   // Stores boundary and middle values on every channel, reads them back.
   // Each channel is read back right after its four settings, so order shows.
   task automatic t_store();
      int ch, g, o, r;
      for (ch = 1; ch <= 4; ch++) begin
         g = 55 + ch * 50;
         o = 255 - ch * 50;
         r = (ch == 1) ? 100 : (ch == 4) ? 200000 : 5000 * ch;
         setc(iccp_pkg::CMD_COUPLING_SET, 3'(ch), 18'(ch % 2 == 0), 1'b0);
         setc(iccp_pkg::CMD_GAIN_SET, 3'(ch), 18'(g), 1'b0);
         setc(iccp_pkg::CMD_OFFSET_SET, 3'(ch), 18'(o), 1'b0);
         setc(iccp_pkg::CMD_RANGE_SET, 3'(ch), 18'(r), 1'b0);
         check_chan(3'(ch), ch % 2 == 0, 8'(g), 8'(o), 18'(r));
      end
      $display("test store done");
   endtask

   // Bad channels and arguments are refused and change nothing.
   task automatic t_reject();
      setc(iccp_pkg::CMD_GAIN_SET, 3'h0, 18'd100, 1'b1);
      setc(iccp_pkg::CMD_GAIN_SET, 3'h5, 18'd100, 1'b1);
      setc(iccp_pkg::CMD_GAIN_SET, 3'h1, 18'd54, 1'b1);
      setc(iccp_pkg::CMD_GAIN_SET, 3'h1, 18'd256, 1'b1);
      setc(iccp_pkg::CMD_OFFSET_SET, 3'h1, 18'd54, 1'b1);
      setc(iccp_pkg::CMD_RANGE_SET, 3'h1, 18'd99, 1'b1);
      setc(iccp_pkg::CMD_RANGE_SET, 3'h1, 18'd200001, 1'b1);
      setc(iccp_pkg::CMD_COUPLING_SET, 3'h1, 18'd2, 1'b1);
      setc(iccp_pkg::CMD_RANGE_QUERY, 3'h5, 18'h0, 1'b1);
      check_chan(3'h1, 1'b0, 8'd105, 8'd205, 18'd100);
      $display("test reject done");
   endtask

   // A command offered while the clock enable is low waits for it.
   task automatic t_enable();
      clk_en = 1'b0;
      fork
         setc(iccp_pkg::CMD_GAIN_SET, 3'h1, 18'd200, 1'b0);
         begin
            repeat (6) @(posedge core_clk);
            #2 clk_en = 1'b1;
         end
      join
      check_chan(3'h1, 1'b0, 8'd200, 8'd205, 18'd100);
      $display("test enable done");
   endtask

   // Every failure code, then a clean run with all channels calibrated.
   task automatic t_cal();
      int ch;
      for (ch = 1; ch <= 4; ch++) begin
         cal_offset_fail = 4'h1 << (ch - 1);
         cal_run(ch * 100);
         query(iccp_pkg::CMD_CALSTATE_QUERY, 3'(ch), iccp_pkg::RSP_CALSTATE, 4);
         cmp_val("calstate", 18'h0, 18'(rsp_code));
         cal_offset_fail = 4'h0;
         cal_gain_fail = 4'h1 << (ch - 1);
         cal_run(ch * 100 + 10);
         cal_gain_fail = 4'h0;
      end
      cal_run(0);
      for (ch = 1; ch <= 4; ch++) begin
         query(iccp_pkg::CMD_CALSTATE_QUERY, 3'(ch), iccp_pkg::RSP_CALSTATE, 4);
         cmp_val("calstate", 18'h1, 18'(rsp_code));
      end
      $display("test cal done");
   endtask

   // Reset for ten cycles, then the scenarios in turn.
   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      cal_offset_fail = 4'h0;
      cal_gain_fail = 4'h0;
      repeat (10) @(posedge core_clk);
      #2 resetn = 1'b1;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_store();
      t_reject();
      t_enable();
      t_cal();
      results();
   end
endmodule
`default_nettype wire
